/* include/rdcw_pkg.sv */
package rdcw_pkg;

  // Timebase: the scheduler counts whole milliseconds.
  localparam int CLK_PERIOD_NS    = 10;
  localparam int TICK_PERIOD_NS   = 1000000;
  localparam int TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Duty cycle, listening window, wakeup header and LED figures, in milliseconds.
  localparam int HALF_PERIOD_MS  = 500;
  localparam int ONE_PERIOD_MS   = 1000;
  localparam int EIGHT_PERIOD_MS = 8000;
  localparam int LISTEN_MS       = 100;
  localparam int HDR_HALF_MS     = 700;
  localparam int HDR_ONE_MS      = 1200;
  localparam int HDR_EIGHT_MS    = 8200;
  localparam int LED_PULSE_MS    = 20;

  typedef enum logic [2:0] {
    PM_ON_NOHDR,
    PM_ON_HDR1,
    PM_ON_HDR8,
    PM_HALF,
    PM_ONE,
    PM_EIGHT
  } rdcw_pmode_t;

  typedef enum logic [1:0] {
    PR_TRANSP,
    PR_AWARE,
    PR_NODE
  } rdcw_proto_t;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_NET  = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_IDLE = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;

  // Control register field positions.
  localparam int CTRL_PM_LSB    = 0;
  localparam int CTRL_PR_LSB    = 4;
  localparam int CTRL_ROUTER    = 6;
  localparam int CTRL_RETRY_LSB = 8;
  localparam int CTRL_HOP_LSB   = 16;

  // Status register bit positions.
  localparam int STAT_RX   = 0;
  localparam int STAT_HDR  = 1;
  localparam int STAT_TXEN = 2;
  localparam int STAT_LED  = 3;
  localparam int STAT_IDLE = 4;
  localparam int STAT_ERR  = 8;

  // Range limits of the link settings.
  localparam logic [5:0] NET_MAX_TRANSP = 6'h3f;
  localparam logic [5:0] NET_MAX_PROTO  = 6'h03;

  // Values after reset.
  localparam logic [7:0]  HOP_RST        = 8'h00;
  localparam logic [5:0]  NET_RST        = 6'h00;
  localparam logic [9:0]  ADDR_RST       = 10'h000;
  localparam logic [1:0]  RETRY_RST      = 2'h0;
  localparam logic [15:0] IDLE_LIMIT_RST = 16'h07d0;

endpackage

/* include/rdcw_sched_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface rdcw_sched_if import rdcw_pkg::*; ();
  rdcw_pmode_t pmode;
  logic [15:0] idle_limit;
  logic        tx_req;
  logic        rf_act;
  logic        rx_on;
  logic        hdr_active;
  logic        tx_enable;
  logic        led;
  logic        link_idle;

  modport sched (
    input  pmode, idle_limit, tx_req, rf_act,
    output rx_on, hdr_active, tx_enable, led, link_idle
  );

  modport ctrl (
    output pmode, idle_limit, tx_req, rf_act,
    input  rx_on, hdr_active, tx_enable, led, link_idle
  );
endinterface
`default_nettype wire

/* logic/rdcw_sched.sv */
`timescale 1ns/10ps
`default_nettype none
module rdcw_sched import rdcw_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
  // Clock and reset
  input  wire logic   ref_clk_i,
  input  wire logic   rstn_i,
  // Scheduler control and status
  rdcw_sched_if.sched sif
);

  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_SEND} rdcw_state_t;

  rdcw_state_t state;
  rdcw_state_t next_state;
  logic [16:0] tick_cnt;
  logic [13:0] phase;
  logic [13:0] hdr_cnt;
  logic [15:0] idle_cnt;
  logic        armed;
  logic        rx_hold;

  wire        ms_tick   = (tick_cnt == 17'(TICK_CYCLES - 1));
  wire        is_on     = (sif.pmode == PM_ON_NOHDR) || (sif.pmode == PM_ON_HDR1)
                          || (sif.pmode == PM_ON_HDR8);
  wire [13:0] period_ms = (sif.pmode == PM_HALF)  ? 14'(HALF_PERIOD_MS) :  // R5
                          (sif.pmode == PM_ONE)   ? 14'(ONE_PERIOD_MS) :   // R8
                          14'(EIGHT_PERIOD_MS);  // R11
  wire [13:0] hdr_ms    = (sif.pmode == PM_ON_HDR1) ? 14'(HDR_ONE_MS) :    // R2
                          (sif.pmode == PM_ON_HDR8) ? 14'(HDR_EIGHT_MS) :  // R3
                          (sif.pmode == PM_HALF)    ? 14'(HDR_HALF_MS) :   // R6
                          (sif.pmode == PM_ONE)     ? 14'(HDR_ONE_MS) :    // R9
                          (sif.pmode == PM_EIGHT)   ? 14'(HDR_EIGHT_MS) :  // R12
                          14'h0000;  // R1
  wire        listen    = (phase < 14'(LISTEN_MS));
  wire        flash     = (phase < 14'(LED_PULSE_MS));
  wire        activity  = sif.rf_act || (state != ST_IDLE);
  wire        idle_hit  = (idle_cnt >= sif.idle_limit);
  wire        hdr_done  = ms_tick && (hdr_cnt == hdr_ms - 14'h0001);

  // A mode change that drops the header ends any header already running.
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (sif.tx_req)
          next_state = (armed && hdr_ms != 14'h0000) ? ST_HDR : ST_SEND;  // R23
      ST_HDR:
        if (hdr_ms == 14'h0000 || hdr_done)
          next_state = ST_SEND;
      ST_SEND:
        if (!sif.tx_req)
          next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      tick_cnt <= 17'h00000;
      phase    <= 14'h0000;
    end
    else
    begin
      tick_cnt <= ms_tick ? 17'h00000 : tick_cnt + 17'h00001;
      if (ms_tick)
        phase <= (phase >= period_ms - 14'h0001) ? 14'h0000 : phase + 14'h0001;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      state   <= ST_IDLE;
      hdr_cnt <= 14'h0000;
    end
    else
    begin
      state   <= next_state;
      hdr_cnt <= (state != ST_HDR) ? 14'h0000 : hdr_cnt + {13'h0000, ms_tick};
    end
  end

  // Any transmit or receive activity restarts the inactivity count.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      idle_cnt <= 16'h0000;
      armed    <= 1'b1;
    end
    else
    begin
      if (activity)
        idle_cnt <= 16'h0000;
      else if (ms_tick && !idle_hit)
        idle_cnt <= idle_cnt + 16'h0001;
      if (idle_hit && !activity)
        armed <= 1'b1;  // R23
      else if (state == ST_HDR && next_state == ST_SEND)
        armed <= 1'b0;
      else if (state == ST_IDLE && next_state == ST_SEND)
        armed <= 1'b0;
    end
  end

  // Activity heard in a window keeps the receiver up until the link goes quiet.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      rx_hold <= 1'b0;
    else if (sif.rf_act && sif.rx_on)
      rx_hold <= 1'b1;
    else if (idle_hit)
      rx_hold <= 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      sif.rx_on      <= 1'b1;
      sif.hdr_active <= 1'b0;
      sif.tx_enable  <= 1'b0;
      sif.led        <= 1'b1;
      sif.link_idle  <= 1'b0;
    end
    else
    begin
      sif.rx_on      <= is_on || listen || rx_hold;  // R1 R5 R8 R11
      sif.hdr_active <= (state == ST_HDR) && (hdr_ms != 14'h0000);
      sif.tx_enable  <= (state == ST_SEND);
      sif.led        <= is_on || flash;  // R4 R7 R10 R13
      sif.link_idle  <= idle_hit;
    end
  end

endmodule
`default_nettype wire

/* logic/rdcw_top.sv */
// Function
// R1: Always-on, no-header mode: receiver always powered, no wakeup header ever sent.
// R2: Always-on short-header mode: receiver on, 1.2 s header after RF inactivity.
// R3: Always-on long-header mode: receiver on, 8.2 s header after RF inactivity.
// R4: Every always-on mode holds the red status LED continuously lit.
// R5: Half-second mode: receiver on 100 ms every 0.5 s, otherwise off. Code keeps it on after activity heard in a window until the link is idle.
// R6: Half-second mode: 700 ms header before first transmission after inactivity.
// R7: Half-second mode: red LED pulses once every 0.5 s.
// R8: One-second mode: receiver on 100 ms every 1 s.
// R9: One-second mode: 1.2 s header before first transmission after inactivity.
// R10: One-second mode: red LED pulses once every 1 s.
// R11: Eight-second mode: receiver on 100 ms every 8 s.
// R12: Eight-second mode: 8.2 s header before first transmission after inactivity.
// R13: Eight-second mode: red LED pulses once every 8 s.
// R14: Hop sequence and network match network-wide; foreign hop traffic ignored.
// R15: Protocol-aware or node modes accept network numbers 0 to 3 only.
// R16: Transparent mode accepts network numbers 0 to 63.
// R17: Radio address used only in transparent mode; traffic needs matching address. Code also drives it out as rf_id_o in node mode.
// R18: Radio address accepted from 0 to 1023, a 10-bit field.
// R19: Transparent mode passes data untouched; retry level forced to none.
// R20: Protocol-aware mode takes the attached equipment's address as RF identifier.
// R21: Protocol-aware and node modes acknowledge packets and retry at RF level.
// R22: Router interface requires node mode; then the device acts as repeater.
// R23: Link counts inactive after set ticks without activity; header then re-armed.
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module rdcw_top import rdcw_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Radio front end
  input  wire logic        rf_activity_i,
  input  wire logic        tx_req_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_hop_i,
  input  wire logic [5:0]  rx_net_i,
  input  wire logic [9:0]  rx_addr_i,
  input  wire logic [11:0] attached_addr_i,
  // Power and link status
  output logic             rx_power_o,
  output logic             hdr_active_o,
  output logic             tx_enable_o,
  output logic             led_red_o,
  // Link behaviour
  output logic             rx_accept_o,
  output logic             ack_enable_o,
  output logic      [1:0]  retry_level_o,
  output logic             repeater_o,
  output logic      [11:0] rf_id_o
);

  rdcw_sched_if sif ();

  rdcw_pmode_t pmode;
  rdcw_proto_t proto;
  logic        router_sel;
  logic [1:0]  retry_level;
  logic [7:0]  hop_sequence_select;
  logic [5:0]  network_number;
  logic [9:0]  link_radio_address;
  logic [15:0] idle_limit;
  logic        cfg_err;
  logic        act_meta;
  logic        act_sync;

  // Bus decode.
  wire        req      = wb_cyc_i && wb_stb_i;
  wire        wr_now   = req && wb_we_i && wb_ack_o;
  wire        hit_ctrl = (wb_adr_i == REG_CTRL);
  wire        hit_net  = (wb_adr_i == REG_NET);
  wire        hit_addr = (wb_adr_i == REG_ADDR);
  wire        hit_idle = (wb_adr_i == REG_IDLE);
  wire        hit_stat = (wb_adr_i == REG_STAT);

  wire [31:0] ctrl_val = {8'h00, hop_sequence_select, 6'h00, retry_level, 1'b0,
                          router_sel, proto, 1'b0, pmode};
  wire [31:0] stat_val = {23'h000000, cfg_err, 3'h0, sif.link_idle, sif.led,
                          sif.tx_enable, sif.hdr_active, sif.rx_on};
  wire [31:0] rd_data  = hit_ctrl ? ctrl_val :
                         hit_net  ? {26'h0000000, network_number} :
                         hit_addr ? {22'h000000, link_radio_address} :
                         hit_idle ? {16'h0000, idle_limit} :
                         hit_stat ? stat_val : 32'h00000000;

  // Byte lanes not selected keep the register's current contents.
  wire [31:0] merged;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign merged[8*gi +: 8] = wb_sel_i[gi] ? wb_dat_i[8*gi +: 8] : rd_data[8*gi +: 8];
    end
  endgenerate

  // Candidate settings carried by a write.
  wire [2:0]  new_pm     = merged[CTRL_PM_LSB +: 3];
  wire [1:0]  new_pr     = merged[CTRL_PR_LSB +: 2];
  wire        new_router = merged[CTRL_ROUTER];
  wire [5:0]  new_net    = merged[5:0];
  wire        pm_ok      = (new_pm <= 3'(PM_EIGHT));
  wire        pr_ok      = (new_pr <= 2'(PR_NODE));
  wire [5:0]  net_max    = (new_pr == 2'(PR_TRANSP)) ? NET_MAX_TRANSP : NET_MAX_PROTO;
  wire [5:0]  cur_max    = (proto == PR_TRANSP) ? NET_MAX_TRANSP : NET_MAX_PROTO;
  wire        router_ok  = !new_router || (new_pr == 2'(PR_NODE));  // R22
  wire        ctrl_ok    = pm_ok && pr_ok && router_ok
                           && (network_number <= net_max);  // R15 R16
  wire        net_ok     = (merged[31:6] == 26'h0000000) && (new_net <= cur_max);  // R15 R16
  wire        addr_ok    = (merged[31:10] == 22'h000000);  // R18

  wire        wr_ctrl    = wr_now && hit_ctrl && ctrl_ok;
  wire        wr_net     = wr_now && hit_net && net_ok;
  wire        wr_addr    = wr_now && hit_addr && addr_ok;
  wire        wr_bad     = wr_now && ((hit_ctrl && !ctrl_ok) || (hit_net && !net_ok)
                           || (hit_addr && !addr_ok));
  wire        err_clr    = wr_now && hit_stat && merged[STAT_ERR];

  // Packet filter: hop, network and, in transparent mode only, radio address.
  wire        hop_match  = (rx_hop_i == hop_sequence_select);  // R14
  wire        net_match  = (rx_net_i == network_number);  // R14
  wire        addr_match = (proto != PR_TRANSP) || (rx_addr_i == link_radio_address);  // R17
  wire        next_accept = rx_valid_i && hop_match && net_match && addr_match;

  wire        is_transp  = (proto == PR_TRANSP);
  wire [1:0]  next_retry = is_transp ? 2'h0 : retry_level;  // R19
  wire        next_ack   = !is_transp;  // R21
  wire        next_rpt   = router_sel && (proto == PR_NODE);  // R22
  wire [11:0] next_rf_id = (proto == PR_AWARE) ? attached_addr_i
                           : {2'h0, link_radio_address};  // R20

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= req && !wb_ack_o;
      wb_dat_o <= (req && !wb_ack_o) ? rd_data : wb_dat_o;
    end
  end

  // A refused write leaves every setting as it was and raises the error flag.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      pmode               <= PM_ON_NOHDR;
      proto               <= PR_TRANSP;
      router_sel          <= 1'b0;
      retry_level         <= RETRY_RST;
      hop_sequence_select <= HOP_RST;
    end
    else if (wr_ctrl)
    begin
      pmode               <= rdcw_pmode_t'(new_pm);
      proto               <= rdcw_proto_t'(new_pr);
      router_sel          <= new_router;
      retry_level         <= merged[CTRL_RETRY_LSB +: 2];
      hop_sequence_select <= merged[CTRL_HOP_LSB +: 8];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      network_number     <= NET_RST;
      link_radio_address <= ADDR_RST;
      idle_limit         <= IDLE_LIMIT_RST;
      cfg_err            <= 1'b0;
    end
    else
    begin
      if (wr_net)
        network_number <= new_net;
      if (wr_addr)
        link_radio_address <= merged[9:0];
      if (wr_now && hit_idle)
        idle_limit <= merged[15:0];
      cfg_err <= wr_bad || (cfg_err && !err_clr);
    end
  end

  // The activity pin is asynchronous to the timebase.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      act_meta <= 1'b0;
      act_sync <= 1'b0;
    end
    else
    begin
      act_meta <= rf_activity_i;
      act_sync <= act_meta;
    end
  end

  assign sif.pmode      = pmode;
  assign sif.idle_limit = idle_limit;
  assign sif.tx_req     = tx_req_i;
  assign sif.rf_act     = act_sync;

  rdcw_sched #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_sched (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .sif       (sif)
  );

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      rx_power_o    <= 1'b1;
      hdr_active_o  <= 1'b0;
      tx_enable_o   <= 1'b0;
      led_red_o     <= 1'b1;
      rx_accept_o   <= 1'b0;
      ack_enable_o  <= 1'b0;
      retry_level_o <= 2'h0;
      repeater_o    <= 1'b0;
      rf_id_o       <= 12'h000;
    end
    else
    begin
      rx_power_o    <= sif.rx_on;
      hdr_active_o  <= sif.hdr_active;
      tx_enable_o   <= sif.tx_enable;
      led_red_o     <= sif.led;
      rx_accept_o   <= next_accept;
      ack_enable_o  <= next_ack;
      retry_level_o <= next_retry;
      repeater_o    <= next_rpt;
      rf_id_o       <= next_rf_id;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  wire mode_on  = (pmode == PM_ON_NOHDR) || (pmode == PM_ON_HDR1) || (pmode == PM_ON_HDR8);
  wire mode_nh  = (pmode == PM_ON_NOHDR);
  wire transp   = (proto == PR_TRANSP);

  sequence s_bus_req;
    req && !wb_ack_o;
  endsequence

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  chk_on_rx_power: assert property (mode_on [*3] |-> rx_power_o)  // R1
    else $error("receiver not powered in an always-on mode");

  chk_on_led_lit: assert property (mode_on [*3] |-> led_red_o)  // R4
    else $error("red LED not lit in an always-on mode");

  chk_nohdr_never: assert property (mode_nh [*4] |-> !hdr_active_o)  // R1
    else $error("wakeup header sent in the no-header mode");

  chk_bus_ack_pulse: assert property (s_bus_req |=> s_ack_pulse)
    else $error("bus answer is not a one-cycle acknowledge");

  chk_net_range: assert property (wr_now && hit_net && !transp && new_net > NET_MAX_PROTO
                                  |=> $stable(network_number) && cfg_err)  // R15
    else $error("out-of-range network number taken");

  chk_net_wide: assert property (wr_now && hit_net && transp && wb_sel_i[0]
                                 && wb_dat_i[31:6] == 26'h0000000
                                 |=> network_number == $past(wb_dat_i[5:0]))  // R16
    else $error("valid transparent network number refused");

  chk_addr_range: assert property (wr_now && hit_addr && merged[31:10] != 22'h000000
                                   |=> $stable(link_radio_address))  // R18
    else $error("radio address above 1023 taken");

  chk_retry_transp: assert property (transp [*2] |-> retry_level_o == 2'h0)  // R19
    else $error("retry enabled in transparent mode");

  chk_ack_proto: assert property (!transp [*2] |-> ack_enable_o)  // R21
    else $error("acknowledge off in a protocol mode");

  chk_router_node: assert property (repeater_o |-> $past(router_sel)
                                    && $past(proto) == PR_NODE)  // R22
    else $error("repeater without node mode");

  chk_hop_filter: assert property (rx_accept_o |-> $past(rx_hop_i) == $past(hop_sequence_select)
                                   && $past(rx_net_i) == $past(network_number))  // R14
    else $error("packet with foreign hop or network accepted");

  chk_addr_filter: assert property (rx_accept_o && $past(transp)
                                    |-> $past(rx_addr_i) == $past(link_radio_address))  // R17
    else $error("transparent packet with other address accepted");

  chk_rf_ident: assert property ((proto == PR_AWARE) [*2]
                                 |-> rf_id_o == $past(attached_addr_i))  // R20
    else $error("RF identifier not taken from attached equipment");

  chk_err_sticky: assert property (wr_bad |=> cfg_err [*2])
    else $error("error flag not held after refused write");

endmodule
`default_nettype wire

/* sim/rdcw_far_radio.sv */
`timescale 1ns/10ps
`default_nettype none
module rdcw_far_radio (
  // Clock
  input  wire logic       ref_clk_i,
  // Air side as seen by the radio under test
  output logic            rf_activity_o,
  output logic            rx_valid_o,
  output logic      [7:0] rx_hop_o,
  output logic      [5:0] rx_net_o,
  output logic      [9:0] rx_addr_o
);
  initial
  begin
    rf_activity_o = 1'b0;
    rx_valid_o    = 1'b0;
    rx_hop_o      = 8'h00;
    rx_net_o      = 6'h00;
    rx_addr_o     = 10'h000;
  end

  // Fields are inverted once the strobe drops, so a stale header never matches.
  task automatic send(input logic [7:0] hop, input logic [5:0] net, input logic [9:0] adr);
    @(posedge ref_clk_i);
    rf_activity_o <= 1'b1;
    rx_valid_o    <= 1'b1;
    rx_hop_o      <= hop;
    rx_net_o      <= net;
    rx_addr_o     <= adr;
    @(posedge ref_clk_i);
    rf_activity_o <= 1'b0;
    rx_valid_o    <= 1'b0;
    rx_hop_o      <= ~hop;
    rx_net_o      <= ~net;
    rx_addr_o     <= ~adr;
  endtask
endmodule
`default_nettype wire

/* sim/rdcw_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module rdcw_tb_top import rdcw_pkg::*; ;
  localparam int T = 4;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'hf;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic        rf_act;
  logic        tx_req = 1'b0;
  logic        rx_valid;
  logic [7:0]  rx_hop;
  logic [5:0]  rx_net;
  logic [9:0]  rx_addr;
  logic [11:0] attached = 12'h000;
  logic        rx_power;
  logic        hdr_active;
  logic        tx_enable;
  logic        led_red;
  logic        rx_accept;
  logic        ack_enable;
  logic [1:0]  retry_level;
  logic        repeater;
  logic [11:0] rf_id;
  logic [9:0]  a;
  int          n_errors = 0;
  int          n_compared = 0;
  int          seed = 32'ha515;
  int          hdr_ms[6] = '{0, HDR_ONE_MS, HDR_EIGHT_MS, HDR_HALF_MS, HDR_ONE_MS, HDR_EIGHT_MS};
  int          per_ms[6] = '{500, 500, 500, HALF_PERIOD_MS, ONE_PERIOD_MS, EIGHT_PERIOD_MS};
  int          ml[$] = '{0, 1, 3, 4, 5};

  always #5 ref_clk = ~ref_clk;

  rdcw_top #(.TICK_CYCLES(T)) u_rdcw_top (
    .ref_clk_i(ref_clk), .rstn_i(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .rf_activity_i(rf_act), .tx_req_i(tx_req),
    .rx_valid_i(rx_valid), .rx_hop_i(rx_hop), .rx_net_i(rx_net), .rx_addr_i(rx_addr),
    .attached_addr_i(attached), .rx_power_o(rx_power), .hdr_active_o(hdr_active),
    .tx_enable_o(tx_enable), .led_red_o(led_red), .rx_accept_o(rx_accept),
    .ack_enable_o(ack_enable), .retry_level_o(retry_level), .repeater_o(repeater),
    .rf_id_o(rf_id));

  rdcw_far_radio u_rdcw_far_radio (
    .ref_clk_i(ref_clk), .rf_activity_o(rf_act), .rx_valid_o(rx_valid),
    .rx_hop_o(rx_hop), .rx_net_o(rx_net), .rx_addr_o(rx_addr));

  task automatic complete_run();
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Counts of cycles; tolerance covers the one-tick phase slack of a header.
  task automatic chk_near(input string nm, input int e, input int g, input int tol);
    n_compared++;
    if (g - e > tol || e - g > tol)
    begin
      n_errors++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] rd);
    int k;
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= d;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (wb_ack !== 1'b1 && k < 20);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    chk_val("wb_ack", 32'h1, 32'(wb_ack));
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, adr, d, x);
  endtask

  task automatic rdc(input string nm, input logic [7:0] adr, input logic [31:0] e);
    logic [31:0] x;
    wb(1'b0, adr, 32'h0, x);
    chk_val(nm, e, x);
  endtask

  task automatic sbit(input int b, input logic e);
    logic [31:0] x;
    wb(1'b0, REG_STAT, 32'h0, x);
    chk_val("stat_bit", 32'(e), 32'(x[b]));
    wr(REG_STAT, 32'h100);
  endtask

  task automatic pkt(input logic [7:0] h, input logic [5:0] n, input logic [9:0] ad,
                     input logic e);
    u_rdcw_far_radio.send(h, n, ad);
    @(posedge ref_clk);
    chk_val("rx_accept", 32'(e), 32'(rx_accept));
  endtask

  task automatic duty(input int m);
    int r;
    int l;
    wr(REG_CTRL, 32'(m));
    // Phase wraps at the first tick only if it lies past the new period, else it keeps counting, so a short settle is enough.
    repeat (4 * T) @(posedge ref_clk);
    r = 0;
    l = 0;
    repeat (per_ms[m] * T)
    begin
      @(posedge ref_clk);
      if (rx_power === 1'b1) r++;
      if (led_red === 1'b1) l++;
    end
    chk_near("rx_on_cycles", ((m < 3) ? per_ms[m] : LISTEN_MS) * T, r, 0);
    chk_near("led_cycles", ((m < 3) ? per_ms[m] : LED_PULSE_MS) * T, l, 0);
  endtask

  task automatic tx_run(input int e_ms);
    int k;
    int h;
    @(posedge ref_clk);
    tx_req <= 1'b1;
    k = 0;
    h = 0;
    while (tx_enable !== 1'b1 && k < 40000)
    begin
      @(posedge ref_clk);
      k++;
      if (hdr_active === 1'b1) h++;
    end
    chk_val("tx_enable", 32'h1, 32'(tx_enable));
    chk_near("hdr_cycles", e_ms * T, h, T);
    @(posedge ref_clk);
    tx_req <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  initial
  begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    attached <= 12'($random(seed));
    chk_val("rx_power", 32'h1, 32'(rx_power));
    chk_val("led_red", 32'h1, 32'(led_red));
    rdc("ctrl", REG_CTRL, 32'h0);
    rdc("idle", REG_IDLE, 32'h7d0);
    rdc("unmapped", 8'h20, 32'h0);
    chk_val("retry", 32'h0, 32'(retry_level));
    wr(REG_IDLE, 32'h2);
    a = 10'($random(seed));
    wr(REG_ADDR, 32'(a));
    rdc("addr", REG_ADDR, 32'(a));
    wr(REG_ADDR, 32'h400);
    rdc("addr", REG_ADDR, 32'(a));
    sbit(STAT_ERR, 1'b1);
    wr(REG_NET, 32'h3f);
    rdc("net", REG_NET, 32'h3f);
    wr(REG_CTRL, 32'h10);
    rdc("ctrl", REG_CTRL, 32'h0);
    sbit(STAT_ERR, 1'b1);
    wr(REG_NET, 32'h3);
    wr(REG_CTRL, 32'h210);
    wr(REG_NET, 32'h4);
    rdc("net", REG_NET, 32'h3);
    sbit(STAT_ERR, 1'b1);
    chk_val("retry", 32'h2, 32'(retry_level));
    chk_val("ack_en", 32'h1, 32'(ack_enable));
    chk_val("rf_id", 32'(attached), 32'(rf_id));
    wr(REG_CTRL, 32'h50);
    sbit(STAT_ERR, 1'b1);
    wr(REG_CTRL, 32'h60);
    repeat (2) @(posedge ref_clk);
    chk_val("repeater", 32'h1, 32'(repeater));
    wr(REG_CTRL, 32'h005a0300);
    repeat (2) @(posedge ref_clk);
    chk_val("retry", 32'h0, 32'(retry_level));
    chk_val("ack_en", 32'h0, 32'(ack_enable));
    wr(REG_NET, 32'h3);
    pkt(8'h5a, 6'h03, a, 1'b1);
    pkt(8'h5b, 6'h03, a, 1'b0);
    pkt(8'h5a, 6'h02, a, 1'b0);
    pkt(8'h5a, 6'h03, ~a, 1'b0);
    wr(REG_CTRL, 32'h005a0010);
    pkt(8'h5a, 6'h03, ~a, 1'b1);
    for (int m = 0; m < 6; m++)
      duty(m);
    foreach (ml[i])
    begin
      wr(REG_CTRL, 32'(ml[i]));
      repeat (20 * T) @(posedge ref_clk);
      sbit(STAT_IDLE, 1'b1);
      tx_run(hdr_ms[ml[i]]);
      if (ml[i] == 3)
        tx_run(0);
    end
    complete_run();
  end

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
